/* File: rtl/flag_unit_pkg.sv */
// package: flag register layout, opcodes, condition codes, reset values
package flag_unit_pkg;
  localparam logic [7:0] FLAGS_ADDR = 8'hE7;
  localparam int BIT_C = 7;
  localparam int BIT_Z = 6;
  localparam int BIT_S = 5;
  localparam int BIT_V = 4;
  localparam int BIT_D = 3;
  localparam int BIT_H = 2;
  localparam int BIT_USER = 1;
  localparam int BIT_SPACE = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [3:0] WIN16_MASK = 4'h0;

  typedef enum logic [4:0] {
    OP_NONE, OP_ALU, OP_WRITE_REG, OP_SPM, OP_SDM, OP_SCF, OP_RCF, OP_CCF,
    OP_INTERRUPT_RETURN, OP_BIT_TEST_THEN_WRITE_ONE, OP_DECREMENT_BYTE_BRANCH_NONZERO, OP_DECREMENT_PAIR_BRANCH_NONZERO, OP_COMPARE_BRANCH_FALSE_ELSE_INCREMENT, OP_COMPARE_BRANCH_TRUE_ELSE_INCREMENT, OP_BIT_TEST_BRANCH_FALSE,
    OP_BIT_TEST_BRANCH_TRUE, OP_JCC, OP_SRP, OP_LOW_WINDOW_POINTER_SET, OP_HIGH_WINDOW_POINTER_SET, OP_WFI, OP_HALT
  } opcode_t;

  typedef enum logic [3:0] {
    CC_F, CC_T, CC_C, CC_NC, CC_Z, CC_NZ, CC_PL, CC_MI, CC_OV, CC_NOV,
    CC_GE, CC_LT, CC_GT, CC_LE, CC_UGT, CC_ULE
  } cond_t;

  typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_DMA, ST_HALT} core_state_t;
endpackage

/* File: rtl/flag_condition_branch_unit.sv */
// flag register, condition evaluator, branch decisions and core stop states
`timescale 1ns/1ps

// Notes on behaviour
// [RULE_01] flag register lives at register-file address 231, six status flags
// [RULE_02] bit 1 is a free user flag, no side effects
// [RULE_03] bit 0 selects program or data space, hardware updates it
// [RULE_04] memory space pin always follows bit 0
// [RULE_05] only carry, zero, sign, overflow feed conditions
// [RULE_06] never, always, and set/clear conditions for C, Z, S, V
// [RULE_07] GE when S xor V is 0, LT when it is 1
// [RULE_08] GT when Z or (S xor V) is 0, LE when 1
// [RULE_09] unsigned: UGE C=0, UL C=1, UGT C=0 and Z=0, ULE C or Z
// [RULE_10] wait-for-interrupt stops execution until enabled interrupt, flags kept
// [RULE_11] DMA request during wait is serviced, then wait resumes
// [RULE_12] halt stops execution until device reset only
// [RULE_13] byte decrement, branch if nonzero, flags kept
// [RULE_14] 16-bit pair decrement, branch if nonzero, flags kept
// [RULE_15] compare, branch if false else increment pointer, flags kept
// [RULE_16] compare, branch if true else increment pointer, flags kept
// [RULE_17] bit test, branch when bit is zero, flags kept
// [RULE_18] bit test, branch when bit is one, flags kept
// [RULE_19] long pointer relocates one block of 16 working registers
// [RULE_20] low pointer relocates lower 8 working registers
// [RULE_21] high pointer relocates upper 8 working registers
// [RULE_22] carry set, clear, invert touch only the carry flag
// [RULE_23] interrupt return restores six flags; bit-test-set sets Z,S, clears V
module flag_condition_branch_unit
  import flag_unit_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic op_valid_in,
  input wire opcode_t opcode_in,
  input wire cond_t cond_in,
  input wire logic [7:0] operand_a_in,
  input wire logic [7:0] operand_b_in,
  input wire logic [15:0] pair_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [5:0] alu_flags_in,
  input wire logic [5:0] saved_flags_in,
  input wire logic irq_in,
  input wire logic dma_req_in,
  input wire logic dma_done_in,
  output logic [7:0] flags_out,
  output logic space_pin_out,
  output logic branch_taken_out,
  output logic decision_valid_out,
  output logic ptr_increment_out,
  output logic [7:0] dec_byte_out,
  output logic [15:0] dec_pair_out,
  output logic bit_value_out,
  output logic [7:0] ptr0_out,
  output logic [7:0] ptr1_out,
  output logic split_mode_out,
  output logic executing_out,
  output logic dma_active_out,
  output logic halted_out
);

  // ******************************************************************
  // condition evaluation
  // ******************************************************************
  // only C, Z, S, V are arguments; D and H cannot reach a jump [RULE_05]
  function automatic logic cond_met(input cond_t cc, input logic c,
                                    input logic z, input logic s,
                                    input logic v);
    logic sv;
    sv = s ^ v;
    case (cc)
      CC_F: cond_met = 1'b0; // [RULE_06]
      CC_T: cond_met = 1'b1; // [RULE_06]
      CC_C: cond_met = c; // [RULE_06] [RULE_09]
      CC_NC: cond_met = ~c; // [RULE_06] [RULE_09]
      CC_Z: cond_met = z; // [RULE_06]
      CC_NZ: cond_met = ~z; // [RULE_06]
      CC_PL: cond_met = ~s; // [RULE_06]
      CC_MI: cond_met = s; // [RULE_06]
      CC_OV: cond_met = v; // [RULE_06]
      CC_NOV: cond_met = ~v; // [RULE_06]
      CC_GE: cond_met = ~sv; // [RULE_07]
      CC_LT: cond_met = sv; // [RULE_07]
      CC_GT: cond_met = ~(z | sv); // [RULE_08]
      CC_LE: cond_met = z | sv; // [RULE_08]
      CC_UGT: cond_met = ~c & ~z; // [RULE_09]
      CC_ULE: cond_met = c | z; // [RULE_09]
      default: cond_met = 1'b0;
    endcase
  endfunction

  // ******************************************************************
  // state
  // ******************************************************************
  logic [7:0] flags;
  logic [7:0] next_flags;
  logic [7:0] ptr0;
  logic [7:0] ptr1;
  logic split_mode;
  core_state_t state;
  core_state_t next_state;

  wire running = (state == ST_RUN);
  wire take = op_valid_in & running;
  wire flag_wr = take & (opcode_in == OP_WRITE_REG) &
                 (reg_addr_in == FLAGS_ADDR); // [RULE_01]

  // ******************************************************************
  // opcode decode
  // ******************************************************************
  // every strobe is gated by take, so a stopped core cannot act on an
  // opcode that is still standing on its inputs; at most one strobe is
  // high in any cycle because the opcode is a single field
  wire do_alu = take & (opcode_in == OP_ALU);
  wire do_spm = take & (opcode_in == OP_SPM);
  wire do_sdm = take & (opcode_in == OP_SDM);
  wire do_scf = take & (opcode_in == OP_SCF);
  wire do_rcf = take & (opcode_in == OP_RCF);
  wire do_ccf = take & (opcode_in == OP_CCF);
  wire do_interrupt_return = take & (opcode_in == OP_INTERRUPT_RETURN);
  wire do_bit_test_then_write_one = take & (opcode_in == OP_BIT_TEST_THEN_WRITE_ONE);
  wire do_srp = take & (opcode_in == OP_SRP);
  wire do_low_window_pointer_set = take & (opcode_in == OP_LOW_WINDOW_POINTER_SET);
  wire do_high_window_pointer_set = take & (opcode_in == OP_HIGH_WINDOW_POINTER_SET);
  wire do_wfi = take & (opcode_in == OP_WFI);
  wire do_halt = take & (opcode_in == OP_HALT);

  // equal-operand test used by both compare-and-branch forms
  wire ops_equal = (operand_a_in == operand_b_in);
  wire tested_bit = operand_a_in[bit_sel_in];
  wire [7:0] dec_byte = operand_a_in - 8'h01; // [RULE_13]
  wire [15:0] dec_pair = pair_in - 16'h0001; // [RULE_14]
  // d and h get no alias here, so no condition can ever see them
  wire flag_c = flags[BIT_C];
  wire flag_z = flags[BIT_Z];
  wire flag_s = flags[BIT_S];
  wire flag_v = flags[BIT_V];
  wire cc_hit = cond_met(cond_in, flag_c, flag_z,
                         flag_s, flag_v); // [RULE_05]

  // ******************************************************************
  // branch decision
  // ******************************************************************
  logic taken;
  logic incr;
  logic decides;
  wire decide_now = take & decides;
  always_comb begin
    taken = 1'b0;
    incr = 1'b0;
    decides = 1'b1;
    case (opcode_in)
      OP_JCC: taken = cc_hit;
      OP_DECREMENT_BYTE_BRANCH_NONZERO: taken = (dec_byte != 8'h00); // [RULE_13]
      OP_DECREMENT_PAIR_BRANCH_NONZERO: taken = (dec_pair != 16'h0000); // [RULE_14]
      OP_COMPARE_BRANCH_FALSE_ELSE_INCREMENT: begin
        taken = ~ops_equal; // [RULE_15]
        incr = ops_equal; // [RULE_15]
      end
      OP_COMPARE_BRANCH_TRUE_ELSE_INCREMENT: begin
        taken = ops_equal; // [RULE_16]
        incr = ~ops_equal; // [RULE_16]
      end
      OP_BIT_TEST_BRANCH_FALSE: taken = ~tested_bit; // [RULE_17]
      OP_BIT_TEST_BRANCH_TRUE: taken = tested_bit; // [RULE_18]
      default: decides = 1'b0;
    endcase
  end

  // ******************************************************************
  // flag register update
  // ******************************************************************
  // branch, pointer and stop opcodes raise none of these strobes, so
  // they keep every flag [RULE_10] [RULE_13] [RULE_17]
  always_comb begin
    next_flags = flags;
    if (flag_wr) begin
      // user bit is plain storage; bit 0 stays with the hardware [RULE_02]
      next_flags[7:1] = reg_wdata_in[7:1];
    end
    if (do_alu) begin
      next_flags[7:2] = alu_flags_in;
    end
    if (do_spm) begin
      next_flags[BIT_SPACE] = 1'b0; // [RULE_03]
    end
    if (do_sdm) begin
      next_flags[BIT_SPACE] = 1'b1; // [RULE_03]
    end
    if (do_scf) begin
      next_flags[BIT_C] = 1'b1; // [RULE_22]
    end
    if (do_rcf) begin
      next_flags[BIT_C] = 1'b0; // [RULE_22]
    end
    if (do_ccf) begin
      next_flags[BIT_C] = ~flags[BIT_C]; // [RULE_22]
    end
    if (do_interrupt_return) begin
      next_flags[7:2] = saved_flags_in; // [RULE_23]
    end
    if (do_bit_test_then_write_one) begin
      next_flags[BIT_Z] = ~tested_bit; // [RULE_23]
      next_flags[BIT_S] = tested_bit; // [RULE_23]
      next_flags[BIT_V] = 1'b0; // [RULE_23]
    end
  end

  // ******************************************************************
  // core stop states
  // ******************************************************************
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (do_wfi) begin
          next_state = ST_WAIT; // [RULE_10]
        end else if (do_halt) begin
          next_state = ST_HALT; // [RULE_12]
        end
      end
      ST_WAIT: begin
        // dma wins over a same-cycle interrupt; wait resumes after it,
        // and an interrupt that is still pending then ends the wait
        if (dma_req_in) begin
          next_state = ST_DMA; // [RULE_11]
        end else if (irq_in) begin
          next_state = ST_RUN; // [RULE_10]
        end
      end
      ST_DMA: begin
        if (dma_done_in) begin
          next_state = ST_WAIT; // [RULE_11]
        end
      end
      ST_HALT: next_state = ST_HALT; // [RULE_12]
      default: next_state = ST_RUN;
    endcase
  end

  // ******************************************************************
  // registers
  // ******************************************************************
  // the space bit restarts at program space with the other flags
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      flags <= FLAGS_RESET;
      state <= ST_RUN; // [RULE_12]
    end else begin
      flags <= next_flags;
      state <= next_state;
    end
  end

  // ******************************************************************
  // window pointers
  // ******************************************************************
  // low operand bits are dropped rather than refused, so a misaligned
  // pointer value silently lands on the window below it
  function automatic logic [7:0] align16(input logic [7:0] v);
    align16 = {v[7:4], WIN16_MASK};
  endfunction

  function automatic logic [7:0] align8(input logic [7:0] v);
    align8 = {v[7:3], 3'h0};
  endfunction

  // long form places one aligned 16-register block; short forms each 8
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      ptr0 <= PTR_RESET;
      ptr1 <= PTR_RESET;
      split_mode <= 1'b0;
    end else if (do_srp) begin
      ptr0 <= align16(operand_a_in); // [RULE_19]
      ptr1 <= align16(operand_a_in) + 8'h08; // [RULE_19]
      split_mode <= 1'b0;
    end else if (do_low_window_pointer_set) begin
      ptr0 <= align8(operand_a_in); // [RULE_20]
      split_mode <= 1'b1;
    end else if (do_high_window_pointer_set) begin
      ptr1 <= align8(operand_a_in); // [RULE_21]
      split_mode <= 1'b1;
    end
  end

  // ******************************************************************
  // decision outputs
  // ******************************************************************
  // decisions are one-cycle pulses; the decrement and bit results are
  // refreshed every cycle and only mean something beside a pulse

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      branch_taken_out <= 1'b0;
      decision_valid_out <= 1'b0;
      ptr_increment_out <= 1'b0;
      dec_byte_out <= 8'h00;
      dec_pair_out <= 16'h0000;
      bit_value_out <= 1'b0;
    end else begin
      branch_taken_out <= decide_now & taken;
      decision_valid_out <= decide_now;
      ptr_increment_out <= decide_now & incr;
      dec_byte_out <= dec_byte;
      dec_pair_out <= dec_pair;
      bit_value_out <= tested_bit;
    end
  end

  // ******************************************************************
  // outputs
  // ******************************************************************
  assign flags_out = flags;
  assign space_pin_out = flags[BIT_SPACE]; // [RULE_04]
  assign ptr0_out = ptr0;
  assign ptr1_out = ptr1;
  assign split_mode_out = split_mode;

  // ******************************************************************
  // status levels
  // ******************************************************************
  // registered copies decoded from the next state, so they switch on
  // the same edge as the state register and carry no decode glitches
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      executing_out <= 1'b1;
      dma_active_out <= 1'b0;
      halted_out <= 1'b0; // [RULE_12]
    end else begin
      executing_out <= (next_state == ST_RUN);
      dma_active_out <= (next_state == ST_DMA); // [RULE_11]
      halted_out <= (next_state == ST_HALT); // [RULE_12]
    end
  end

endmodule

/* File: test/flag_unit_monitor.sv */
// port checker for the flag, condition and branch unit
`timescale 1ns/1ps
module flag_unit_monitor
  import flag_unit_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic op_valid_in,
  input wire opcode_t opcode_in,
  input wire cond_t cond_in,
  input wire logic [7:0] operand_a_in,
  input wire logic [7:0] flags_out,
  input wire logic space_pin_out,
  input wire logic branch_taken_out,
  input wire logic decision_valid_out,
  input wire logic executing_out,
  input wire logic dma_active_out,
  input wire logic halted_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  wire take = op_valid_in && executing_out;
  wire jcc = take && opcode_in == OP_JCC;
  chk_space_follow: assert property (space_pin_out == flags_out[0])
    else $error("space pin mismatch");
  chk_never_taken: assert property (jcc && cond_in == CC_F |=>
    decision_valid_out && !branch_taken_out) else $error("never taken");
  chk_signed_ge: assert property (jcc && cond_in == CC_GE |=>
    branch_taken_out == !($past(flags_out[5]) ^ $past(flags_out[4])))
    else $error("signed ge wrong");
  chk_byte_loop: assert property (take && opcode_in == OP_DECREMENT_BYTE_BRANCH_NONZERO |=>
    branch_taken_out == ($past(operand_a_in) != 8'h01))
    else $error("byte loop wrong");
  chk_branch_flags: assert property (take && opcode_in inside
    {OP_DECREMENT_BYTE_BRANCH_NONZERO, OP_DECREMENT_PAIR_BRANCH_NONZERO, OP_COMPARE_BRANCH_FALSE_ELSE_INCREMENT, OP_COMPARE_BRANCH_TRUE_ELSE_INCREMENT, OP_BIT_TEST_BRANCH_FALSE, OP_BIT_TEST_BRANCH_TRUE}
    |=> $stable(flags_out)) else $error("branch moved flags");
  chk_carry_set: assert property (take && opcode_in == OP_SCF |=>
    flags_out == {1'b1, $past(flags_out[6:0])}) else $error("carry set");
  chk_halt_hold: assert property (halted_out |=>
    halted_out && !executing_out) else $error("halt left");
  chk_wait_frozen: assert property (!executing_out |=>
    $stable(flags_out)) else $error("flags moved while stopped");
  cover property (take && opcode_in == OP_HALT);
  cover property (dma_active_out);
  cover property (decision_valid_out && branch_taken_out);
endmodule
bind flag_condition_branch_unit flag_unit_monitor u_mon (.sys_clk_in,
  .nrst_in, .op_valid_in, .opcode_in, .cond_in, .operand_a_in, .flags_out,
  .space_pin_out, .branch_taken_out, .decision_valid_out, .executing_out,
  .dma_active_out, .halted_out);

/* File: test/tb_top.sv */
// self-checking bench for the flag, condition and branch unit
`timescale 1ns/1ps
module tb_top;
  import flag_unit_pkg::*;
  logic sys_clk_in = 0, nrst_in = 0, op_valid_in = 0, irq_in = 0;
  logic dma_req_in = 0, dma_done_in = 0;
  opcode_t opcode_in = OP_NONE;
  cond_t cond_in = CC_F;
  logic [7:0] operand_a_in = 0, operand_b_in = 0, reg_addr_in = 0;
  logic [7:0] reg_wdata_in = 0, flags_out, ptr0_out, ptr1_out, dec_byte_out;
  logic [15:0] pair_in = 0, dec_pair_out;
  logic [2:0] bit_sel_in = 0;
  logic [5:0] alu_flags_in = 0, saved_flags_in = 0;
  logic space_pin_out, branch_taken_out, decision_valid_out;
  logic ptr_increment_out, bit_value_out, split_mode_out, executing_out;
  logic dma_active_out, halted_out;
  logic [7:0] ef, r;
  logic [1:0] note_q[$];
  int n_mismatch = 0, n_compared = 0;
  flag_condition_branch_unit u_dut (.sys_clk_in, .nrst_in, .op_valid_in,
    .opcode_in, .cond_in, .operand_a_in, .operand_b_in, .pair_in,
    .bit_sel_in, .reg_addr_in, .reg_wdata_in, .alu_flags_in,
    .saved_flags_in, .irq_in, .dma_req_in, .dma_done_in, .flags_out,
    .space_pin_out, .branch_taken_out, .decision_valid_out,
    .ptr_increment_out, .dec_byte_out, .dec_pair_out, .bit_value_out,
    .ptr0_out, .ptr1_out, .split_mode_out, .executing_out,
    .dma_active_out, .halted_out);
  initial forever #12.5 sys_clk_in = ~sys_clk_in;
  task automatic check(logic [23:0] got, logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bench's own view of the condition table, indexed by cond_t
  function automatic logic cond_ok(cond_t c, logic [7:0] f);
    logic x, g;
    logic [15:0] v;
    x = f[5] ^ f[4];
    g = f[6] | x;
    v = {f[7] | f[6], ~(f[7] | f[6]), g, ~g, x, ~x, ~f[4], f[4], f[5],
      ~f[5], ~f[6], f[6], ~f[7], f[7], 2'b10};
    return v[c];
  endfunction
  // a also feeds write data and both flag inputs, b the register address and bit select
  task automatic issue(opcode_t o, cond_t c, logic [7:0] a, logic [7:0] b,
    logic [15:0] p);
    @(posedge sys_clk_in);
    op_valid_in <= 1;
    opcode_in <= o;
    cond_in <= c;
    operand_a_in <= a;
    reg_wdata_in <= a;
    alu_flags_in <= a[7:2];
    saved_flags_in <= a[7:2];
    operand_b_in <= b;
    reg_addr_in <= b;
    bit_sel_in <= b[2:0];
    pair_in <= p;
    @(posedge sys_clk_in);
    op_valid_in <= 0;
    #1;
  endtask
  task automatic dec(opcode_t o, cond_t c, logic [7:0] a, logic [7:0] b,
    logic [15:0] p, logic tk, logic inc);
    note_q.push_back({tk, inc});
    issue(o, c, a, b, p);
    check(flags_out, ef);
  endtask
  always @(posedge sys_clk_in) begin
    if (nrst_in === 1'b1 && decision_valid_out === 1'b1) begin
      if (note_q.size() == 0) check(1, 0);
      else check({branch_taken_out, ptr_increment_out}, note_q.pop_front());
    end
  end
  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #(25 * 4000);
    n_mismatch++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h9c397aec));
    repeat (12) @(posedge sys_clk_in);
    nrst_in <= 1;
    ef = FLAGS_RESET;
    #1;
    check({executing_out, flags_out}, {1'b1, ef});
    r = $urandom;
    issue(OP_WRITE_REG, CC_F, r, FLAGS_ADDR, 0);
    ef = {r[7:1], ef[0]};
    check(flags_out, ef);
    issue(OP_WRITE_REG, CC_F, ~r, 8'hE6, 0);
    check(flags_out, ef);
    issue(OP_SDM, CC_F, 0, 0, 0);
    ef[0] = 1;
    check({space_pin_out, flags_out}, {1'b1, ef});
    issue(OP_SPM, CC_F, 0, 0, 0);
    ef[0] = 0;
    check({space_pin_out, flags_out}, {1'b0, ef});
    for (int i = 0; i < 16; i++) begin
      r = {i[3:0], 4'($urandom)};
      issue(OP_ALU, CC_F, r, 0, 0);
      ef[7:2] = r[7:2];
      for (int c = 0; c < 16; c++)
        dec(OP_JCC, cond_t'(c), 0, 0, 0, cond_ok(cond_t'(c), ef), 0);
    end
    issue(OP_SCF, CC_F, 0, 0, 0);
    ef[7] = 1;
    check(flags_out, ef);
    issue(OP_CCF, CC_F, 0, 0, 0);
    ef[7] = 0;
    check(flags_out, ef);
    issue(OP_RCF, CC_F, 0, 0, 0);
    check(flags_out, ef);
    r = $urandom;
    issue(OP_INTERRUPT_RETURN, CC_F, r, 0, 0);
    ef[7:2] = r[7:2];
    check(flags_out, ef);
    issue(OP_BIT_TEST_THEN_WRITE_ONE, CC_F, r, 8'h03, 0);
    ef[6:4] = {~r[3], r[3], 1'b0};
    check(flags_out, ef);
    dec(OP_DECREMENT_BYTE_BRANCH_NONZERO, CC_F, 8'h01, 0, 0, 0, 0);
    dec(OP_DECREMENT_BYTE_BRANCH_NONZERO, CC_F, 8'h00, 0, 0, 1, 0);
    check(dec_byte_out, 8'hFF);
    dec(OP_DECREMENT_PAIR_BRANCH_NONZERO, CC_F, 0, 0, 16'h0001, 0, 0);
    dec(OP_DECREMENT_PAIR_BRANCH_NONZERO, CC_F, 0, 0, 16'h0100, 1, 0);
    check(dec_pair_out, 16'h00FF);
    dec(OP_COMPARE_BRANCH_FALSE_ELSE_INCREMENT, CC_F, r, r, 0, 0, 1);
    dec(OP_COMPARE_BRANCH_FALSE_ELSE_INCREMENT, CC_F, r, ~r, 0, 1, 0);
    dec(OP_COMPARE_BRANCH_TRUE_ELSE_INCREMENT, CC_F, r, r, 0, 1, 0);
    dec(OP_COMPARE_BRANCH_TRUE_ELSE_INCREMENT, CC_F, r, ~r, 0, 0, 1);
    dec(OP_BIT_TEST_BRANCH_FALSE, CC_F, r, 8'h05, 0, ~r[5], 0);
    dec(OP_BIT_TEST_BRANCH_TRUE, CC_F, r, 8'h05, 0, r[5], 0);
    check(bit_value_out, r[5]);
    issue(OP_SRP, CC_F, 8'h5B, 0, 0);
    check({split_mode_out, ptr0_out, ptr1_out}, 17'h05058);
    issue(OP_LOW_WINDOW_POINTER_SET, CC_F, 8'h2F, 0, 0);
    check({split_mode_out, ptr0_out, ptr1_out}, 17'h12858);
    issue(OP_HIGH_WINDOW_POINTER_SET, CC_F, 8'hC3, 0, 0);
    check({split_mode_out, ptr0_out, ptr1_out, flags_out}, {17'h128C0, ef});
    issue(OP_WFI, CC_F, 0, 0, 0);
    issue(OP_SCF, CC_F, 0, 0, 0);
    check({executing_out, flags_out}, {1'b0, ef});
    @(posedge sys_clk_in);
    dma_req_in <= 1;
    @(posedge sys_clk_in);
    dma_req_in <= 0;
    dma_done_in <= 1;
    #1;
    check(dma_active_out, 1);
    @(posedge sys_clk_in);
    dma_done_in <= 0;
    irq_in <= 1;
    #1;
    check({executing_out, dma_active_out}, 0);
    @(posedge sys_clk_in);
    irq_in <= 0;
    #1;
    check(executing_out, 1);
    issue(OP_HALT, CC_F, 0, 0, 0);
    @(posedge sys_clk_in);
    irq_in <= 1;
    repeat (3) @(posedge sys_clk_in);
    nrst_in <= 0;
    #1;
    check({halted_out, executing_out}, 2'b10);
    @(posedge sys_clk_in);
    nrst_in <= 1;
    irq_in <= 0;
    #1;
    check({halted_out, executing_out, flags_out}, 10'h100);
    repeat (2) @(posedge sys_clk_in);
    check(24'(note_q.size()), 0);
    finish_test();
  end
endmodule
